// *** design/rtca_defines.svh ***
// constants of the three-wire access port
`ifndef RTCA_DEFINES_SVH
`define RTCA_DEFINES_SVH
`define RTCA_MODE_WR 4'h3
`define RTCA_MODE_RD 4'hC
`define RTCA_FOS_ADDR 4'h0
`define RTCA_FOS_MASK 8'h80
`define RTCA_MEM_DEPTH 16
`define RTCA_SYNC_W 6
`define RTCA_IX_CEA 0
`define RTCA_IX_CEB 1
`define RTCA_IX_SCLK 2
`define RTCA_IX_DIN 3
`define RTCA_IX_OSC 4
`define RTCA_IX_DROP 5
`define RTCA_NIB_LAST 3'h3
`define RTCA_BIT_LAST 3'h7
`endif

// *** design/rtca_pin_if.sv ***
// filtered pin levels and shift-clock edges between the port modules
`timescale 1ns/1ns
`include "rtca_defines.svh"
interface rtca_pin_if;
  logic [`RTCA_SYNC_W-1:0] filt;
  logic sclk_rise;
  logic sclk_fall;
  modport sync (output filt, output sclk_rise, output sclk_fall);
  modport core (input filt, input sclk_rise, input sclk_fall);
endinterface // rtca_pin_if

// *** design/rtca_pin_sync.sv ***
// three-stage pin synchroniser with agreement filter and clock edges
`timescale 1ns/1ns
`include "rtca_defines.svh"
module rtca_pin_sync
  import rtca_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic reset, // async reset, high
  input wire logic [`RTCA_SYNC_W-1:0] raw, // pins from outside
  rtca_pin_if.sync pins // filtered levels and edges
);
  logic [`RTCA_SYNC_W-1:0] ff1;
  logic [`RTCA_SYNC_W-1:0] ff2;
  logic [`RTCA_SYNC_W-1:0] ff3;
  logic [`RTCA_SYNC_W-1:0] filt;
  logic sclk_prev;

  genvar i;
  generate
    for (i = 0; i < `RTCA_SYNC_W; i++)
    begin : g_bit
      always_ff @(posedge core_clk or posedge reset)
      begin
        if (reset)
        begin
          ff1[i] <= 1'b0;
          ff2[i] <= 1'b0;
          ff3[i] <= 1'b0;
          filt[i] <= 1'b0;
        end
        else
        begin
          ff1[i] <= raw[i];
          ff2[i] <= ff1[i];
          ff3[i] <= ff2[i];
          // change taken only once stages two and three agree
          if (ff2[i] == ff3[i])
            filt[i] <= ff3[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      sclk_prev <= 1'b0;
    else
      sclk_prev <= filt[`RTCA_IX_SCLK];
  end

  assign pins.filt = filt;
  assign pins.sclk_rise = filt[`RTCA_IX_SCLK] & ~sclk_prev;
  assign pins.sclk_fall = ~filt[`RTCA_IX_SCLK] & sclk_prev;
endmodule // rtca_pin_sync

// *** design/rtca_pkg.sv ***
// types of the three-wire access port
package rtca_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MODE,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } rtca_state_e;
  typedef logic [7:0] rtca_byte_t;
endpackage

// *** design/rtca_serial_port.sv ***
// serial access port of the clock module: frame decode and register file
`timescale 1ns/1ns
`include "rtca_defines.svh"
module rtca_serial_port
  import rtca_pkg::*;
(
  input wire logic core_clk, // core clock, 100 MHz
  input wire logic reset, // async reset, high
  input wire logic chip_enable_a, // first chip enable pin
  input wire logic chip_enable_b, // second chip enable pin
  input wire logic shift_clk, // host shift clock pin
  input wire logic data_in, // data pin, input side
  output logic data_out, // data pin, output side
  output logic data_oe, // data pin drive enable
  input wire logic osc_running, // crystal oscillator running
  input wire logic backup_drop, // supply dropped in backup
  output logic core_halt, // calendar functions halted
  output logic wr_strobe, // one-cycle register write pulse
  output logic [3:0] wr_addr, // written register address
  output logic [7:0] wr_data // written register value
);
  rtca_pin_if pins();

  rtca_pin_sync u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .raw({backup_drop, osc_running, data_in, shift_clk,
          chip_enable_b, chip_enable_a}),
    .pins(pins.sync)
  );

  rtca_state_e state;
  logic [2:0] bit_cnt;
  rtca_byte_t shreg;
  logic [3:0] addr;
  logic is_read;
  rtca_byte_t rd_byte;
  logic fos;
  rtca_byte_t mem [`RTCA_MEM_DEPTH];

  wire sel = pins.filt[`RTCA_IX_CEA] & pins.filt[`RTCA_IX_CEB];
  wire din = pins.filt[`RTCA_IX_DIN];
  wire rise = pins.sclk_rise & sel;
  wire fall = pins.sclk_fall & sel;
  wire [7:0] next_shreg = {din, shreg[7:1]};
  wire [3:0] nibble = next_shreg[7:4];
  wire last_nib = bit_cnt == `RTCA_NIB_LAST;
  wire last_bit = bit_cnt == `RTCA_BIT_LAST;
  wire mode_wr = nibble == `RTCA_MODE_WR;
  wire mode_rd = nibble == `RTCA_MODE_RD;
  wire [3:0] next_addr = addr + 4'h1;
  wire byte_done_wr = rise && state == ST_WDATA && last_bit;
  wire byte_done_rd = rise && state == ST_RDATA && last_bit;
  wire [3:0] rd_ptr = (state == ST_ADDR) ? nibble : next_addr;
  wire [7:0] rd_raw = mem[rd_ptr];
  wire [7:0] rd_fetch = (rd_ptr == `RTCA_FOS_ADDR)
    ? ((rd_raw & ~`RTCA_FOS_MASK) | (fos ? `RTCA_FOS_MASK : 8'h00))
    : rd_raw;
  wire fos_clear = byte_done_wr && addr == `RTCA_FOS_ADDR &&
    (next_shreg & `RTCA_FOS_MASK) == 8'h00;
  wire fos_set = pins.filt[`RTCA_IX_DROP];

  // frame sequencer
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      state <= ST_IDLE;
    else if (!sel)
      state <= ST_IDLE;
    else
    begin
      unique case (state)
        ST_IDLE:
          state <= ST_MODE;
        ST_MODE:
          if (rise && last_nib)
            state <= (mode_wr || mode_rd) ? ST_ADDR : ST_IGNORE;
        ST_ADDR:
          if (rise && last_nib)
            state <= is_read ? ST_RDATA : ST_WDATA;
        ST_WDATA, ST_RDATA, ST_IGNORE:
          state <= state;
      endcase
    end
  end

  // bit counter, shifter, mode and address
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      addr <= 4'h0;
      is_read <= 1'b0;
    end
    else if (state == ST_IDLE)
      bit_cnt <= 3'h0;
    else if (rise && state != ST_IGNORE)
    begin
      shreg <= next_shreg;
      bit_cnt <= (state inside {ST_MODE, ST_ADDR}) && last_nib
        ? 3'h0 : bit_cnt + 3'h1;
      if (state == ST_MODE && last_nib)
        is_read <= mode_rd;
      if (state == ST_ADDR && last_nib)
        addr <= nibble;
      else if (byte_done_wr || byte_done_rd)
        addr <= next_addr;
    end
  end

  // register file, one byte per completed write
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      for (int k = 0; k < `RTCA_MEM_DEPTH; k++)
        mem[k] <= 8'h00;
    end
    else if (byte_done_wr)
      mem[addr] <= next_shreg;
  end

  // oscillator-stop flag, hardware set wins over clear
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      fos <= 1'b1;
    else if (fos_set)
      fos <= 1'b1;
    else if (fos_clear)
      fos <= 1'b0;
  end

  // read shifter and data pin drive
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      rd_byte <= 8'h00;
      data_out <= 1'b0;
      data_oe <= 1'b0;
    end
    else
    begin
      if ((state == ST_ADDR && rise && last_nib) || byte_done_rd)
        rd_byte <= rd_fetch;
      if (!sel || state != ST_RDATA)
        data_oe <= 1'b0;
      else if (fall)
      begin
        data_out <= rd_byte[bit_cnt];
        data_oe <= 1'b1;
      end
    end
  end

  // outputs to the calendar core
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      core_halt <= 1'b1;
      wr_strobe <= 1'b0;
      wr_addr <= 4'h0;
      wr_data <= 8'h00;
    end
    else
    begin
      core_halt <= ~pins.filt[`RTCA_IX_OSC];
      wr_strobe <= byte_done_wr;
      if (byte_done_wr)
      begin
        wr_addr <= addr;
        wr_data <= next_shreg;
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  AST_MODE_LEN: assert property (
    rise && state == ST_MODE && last_nib && sel
    |=> bit_cnt == 3'h0 && state inside {ST_ADDR, ST_IGNORE})
    else $error("mode nibble not four bits");
  AST_LSB_FIRST: assert property (
    byte_done_wr |=> wr_strobe && wr_data[7] == $past(din))
    else $error("last bit received is not the byte msb");
  AST_ADDR_WRAP: assert property (
    (byte_done_wr || byte_done_rd) |=> addr == 4'($past(addr) + 4'h1))
    else $error("address did not advance by one");
  AST_WRITE_STORE: assert property (
    wr_strobe |-> mem[wr_addr] == wr_data)
    else $error("written byte not stored");
  AST_READ_ADDR: assert property (
    state == ST_ADDR && rise && last_nib && is_read && sel
    |=> state == ST_RDATA && addr == $past(nibble))
    else $error("read address not taken");
  AST_PARTIAL_DROP: assert property (
    !sel |=> !wr_strobe ##1 !wr_strobe)
    else $error("write after deselect");
  AST_BAD_MODE: assert property (
    state == ST_IGNORE |=> !data_oe && !wr_strobe)
    else $error("ignored frame had effect");
  AST_FOS_SET: assert property (
    fos_set |=> fos)
    else $error("stop flag not set on supply loss");
  AST_HALT: assert property (
    !pins.filt[`RTCA_IX_OSC] |=> core_halt)
    else $error("core not halted with oscillator stopped");
  AST_DESELECT: assert property (
    !sel |=> state == ST_IDLE && !data_oe)
    else $error("frame continued after deselect");
  AST_FALL_DRIVE: assert property (
    fall && state == ST_RDATA
    |=> data_oe && data_out == $past(rd_byte[bit_cnt]))
    else $error("read bit not driven on falling edge");

  COV_WRITE: cover property (wr_strobe);
  COV_READ: cover property (byte_done_rd);
  COV_IGNORE: cover property (state == ST_IGNORE);
  COV_WRAP: cover property ((byte_done_wr || byte_done_rd) && addr == 4'hF);
endmodule // rtca_serial_port

// *** sim/rtc_three_wire_access_test.sv ***
// self-checking bench for the three-wire access port
`timescale 1ns/1ns
module rtc_three_wire_access_test
  import rtca_pkg::*;
();
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic osc_running = 1'b1;
  logic backup_drop = 1'b0;
  logic ce_a, ce_b, sclk, line, dout, doe, halt, wstb;
  logic [3:0] waddr;
  rtca_byte_t wdata;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [11:0] wq[$];
  logic oe_seen = 1'b0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
    cyc <= cyc + 1;
  always @(negedge core_clk)
  begin
    if (wstb === 1'b1)
      wq.push_back({waddr, wdata});
    if (doe === 1'b1)
      oe_seen <= 1'b1;
  end
  always @(negedge core_clk)
    if (cyc == 30000)
    begin
      bad_count++;
      summarize();
    end
  rtca_host i_rtca_host (.core_clk(core_clk), .dev_out(dout),
    .dev_oe(doe), .ce_a(ce_a), .ce_b(ce_b), .sclk(sclk), .line(line));
  rtca_serial_port i_rtca_serial_port (.core_clk(core_clk),
    .reset(reset), .chip_enable_a(ce_a), .chip_enable_b(ce_b),
    .shift_clk(sclk), .data_in(line), .data_out(dout), .data_oe(doe),
    .osc_running(osc_running), .backup_drop(backup_drop),
    .core_halt(halt), .wr_strobe(wstb), .wr_addr(waddr),
    .wr_data(wdata));
  task automatic summarize();
    if (bad_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] e,
    input logic [11:0] g);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rd1(input logic [3:0] a, output rtca_byte_t b);
    i_rtca_host.head(4'hC, a, 1'b1, 1'b1);
    i_rtca_host.get_byte(b);
    i_rtca_host.desel();
  endtask
  task automatic wr1(input logic [3:0] a, input rtca_byte_t d);
    i_rtca_host.head(4'h3, a, 1'b1, 1'b1);
    i_rtca_host.put_byte(d);
    i_rtca_host.desel();
  endtask
  task automatic t_flag();
    rtca_byte_t b;
    rd1(4'h0, b);
    chk("stop flag", 12'h080, {4'h0, b});
    wr1(4'h0, 8'h00);
    rd1(4'h0, b);
    chk("flag cleared", 12'h000, {4'h0, b});
  endtask
  task automatic t_wrap();
    rtca_byte_t d[3] = '{8'h11, 8'h22, 8'h33};
    rtca_byte_t b;
    wq.delete();
    i_rtca_host.head(4'h3, 4'hE, 1'b1, 1'b1);
    for (int i = 0; i < 3; i++)
      i_rtca_host.put_byte(d[i]);
    i_rtca_host.desel();
    chk("write count", 12'h003, 12'(wq.size()));
    for (int i = 0; i < 3; i++)
      chk("write", {4'(4'hE + i), d[i]}, wq[i]);
    i_rtca_host.head(4'hC, 4'hE, 1'b1, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      i_rtca_host.get_byte(b);
      chk("read", {4'h0, d[i]}, {4'h0, b});
    end
    i_rtca_host.desel();
  endtask
  task automatic t_partial();
    logic s;
    rtca_byte_t b;
    wq.delete();
    i_rtca_host.head(4'h3, 4'h5, 1'b1, 1'b1);
    i_rtca_host.put_byte(8'hA5);
    for (int i = 0; i < 3; i++)
      i_rtca_host.xbit(1'b1, 1'b1, s);
    i_rtca_host.desel();
    chk("partial count", 12'h001, 12'(wq.size()));
    chk("partial first", 12'h5A5, wq[0]);
    rd1(4'h6, b);
    chk("partial byte", 12'h000, {4'h0, b});
  endtask
  task automatic t_bad();
    rtca_byte_t b;
    wq.delete();
    oe_seen = 1'b0;
    for (int m = 0; m < 16; m++)
      if (m != 3 && m != 12)
      begin
        i_rtca_host.head(4'(m), 4'h2, 1'b1, 1'b1);
        i_rtca_host.put_byte(8'hFF);
        i_rtca_host.desel();
      end
    chk("bad mode drive", 12'h000, {11'h0, oe_seen});
    i_rtca_host.head(4'h3, 4'h2, 1'b1, 1'b0);
    i_rtca_host.put_byte(8'h5A);
    i_rtca_host.desel();
    i_rtca_host.head(4'h3, 4'h2, 1'b0, 1'b1);
    i_rtca_host.put_byte(8'h5A);
    i_rtca_host.desel();
    chk("ignored writes", 12'h000, 12'(wq.size()));
    rd1(4'h2, b);
    chk("ignored data", 12'h000, {4'h0, b});
  endtask
  task automatic t_osc();
    rtca_byte_t b;
    @(negedge core_clk);
    osc_running = 1'b0;
    repeat (8) @(negedge core_clk);
    chk("halt on", 12'h001, {11'h0, halt});
    osc_running = 1'b1;
    backup_drop = 1'b1;
    repeat (8) @(negedge core_clk);
    chk("halt off", 12'h000, {11'h0, halt});
    backup_drop = 1'b0;
    rd1(4'h0, b);
    chk("drop flag", 12'h0B3, {4'h0, b});
  endtask
  task automatic t_reset();
    rtca_byte_t b;
    wr1(4'h0, 8'h00);
    @(negedge core_clk);
    reset = 1'b1;
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
    repeat (4) @(negedge core_clk);
    rd1(4'h0, b);
    chk("reset flag", 12'h080, {4'h0, b});
  endtask
  initial
  begin
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    repeat (4) @(negedge core_clk);
    t_flag();
    t_wrap();
    t_partial();
    t_bad();
    t_osc();
    t_reset();
    summarize();
  end
endmodule // rtc_three_wire_access_test

// *** sim/rtca_host.sv ***
// host model driving the three-wire access port
`timescale 1ns/1ns
module rtca_host
(
  input wire logic core_clk, // core clock
  input wire logic dev_out, // device data
  input wire logic dev_oe, // device drives data
  output logic ce_a, // chip enable a
  output logic ce_b, // chip enable b
  output logic sclk, // shift clock
  output logic line // resolved data wire
);
  logic drv = 1'b0;
  logic val = 1'b0;
  // no pull on the wire: undriven shows inverse of last value
  assign line = dev_oe ? dev_out : (drv ? val : ~val);
  initial
  begin
    ce_a = 1'b0;
    ce_b = 1'b0;
    sclk = 1'b0;
  end
  task automatic xbit(input logic d, input logic en, output logic s);
    drv = en;
    val = en ? d : val;
    repeat (7) @(negedge core_clk);
    sclk = 1'b1;
    s = line;
    repeat (6) @(negedge core_clk);
    sclk = 1'b0;
  endtask
  task automatic put_nib(input logic [3:0] v);
    logic s;
    for (int i = 0; i < 4; i++)
      xbit(v[i], 1'b1, s);
  endtask
  task automatic put_byte(input logic [7:0] v);
    logic s;
    for (int i = 0; i < 8; i++)
      xbit(v[i], 1'b1, s);
  endtask
  task automatic get_byte(output logic [7:0] v);
    logic s;
    for (int i = 0; i < 8; i++)
    begin
      xbit(1'b0, 1'b0, s);
      v[i] = s;
    end
  endtask
  task automatic head(input logic [3:0] m, input logic [3:0] a,
    input logic ea, input logic eb);
    @(negedge core_clk);
    ce_a = ea;
    ce_b = eb;
    repeat (8) @(negedge core_clk);
    put_nib(m);
    put_nib(a);
  endtask
  task automatic desel();
    repeat (3) @(negedge core_clk);
    drv = 1'b0;
    ce_a = 1'b0;
    ce_b = 1'b0;
    repeat (8) @(negedge core_clk);
  endtask
endmodule // rtca_host
